// ---- hdl/txp_bb.sv ----
// baseband end of the transmit port: sends i/q pairs as a marked stream
`default_nettype none
module txp_bb
   import txp_pkg::*;
#(
   parameter int W = TXP_SAMPLE_W,
   parameter int HALF = TXP_HALF_CYC
) (
   input wire logic i_sys_clk,          // system clock
   input wire logic i_srst,             // sync reset, high
   input wire logic i_smp_valid,        // pair offered
   output logic o_smp_ready,            // pair accepted this cycle
   input wire logic [W-1:0] i_i_sample, // in-phase sample
   input wire logic [W-1:0] i_q_sample, // quadrature sample
   input wire logic i_make_clock,       // we drive the clock (mode 01)
   input wire logic i_run_clock,        // run our clock
   input wire logic i_use_shared_pin,   // half duplex one-clock mode
   input wire logic i_single_edge,      // mirror of rate bit
   input wire logic i_sample_rising,    // mirror of edge bit
   input wire logic i_marker_pol,       // mirror of polarity bit
   input wire logic i_in_phase_first,   // mirror of ordering bit
   txp_if.bb lnk                        // link pins
);
   typedef struct packed {
      logic [7:0] div;
      logic gen;
      logic [1:0] own_dly;
      logic [1:0] ck_sync;
      logic ck_prev;
      logic pair_v;
      logic [W-1:0] pi;
      logic [W-1:0] pq;
      txp_pair_t st;
      logic [W-1:0] txd;
      logic mark;
   } txp_bb_st_t;

   txp_bb_st_t r;
   txp_bb_st_t n;
   logic seen;
   logic launch;

   assign o_smp_ready = !r.pair_v;
   assign lnk.transmit_clock_bb_o = r.gen;
   assign lnk.transmit_clock_bb_oe = i_make_clock && !i_use_shared_pin;
   assign lnk.shared_port_clock_bb_o = r.gen;
   assign lnk.shared_port_clock_bb_oe = i_make_clock && i_use_shared_pin;
   assign lnk.txd = r.txd;
   assign lnk.tx_pair_marker = r.mark;

   // launch half a period ahead of the converter's capture edge
   assign seen = i_make_clock ? r.own_dly[1] : r.ck_sync[1];
   assign launch = i_single_edge
                   ? (i_sample_rising ? (!seen && r.ck_prev)
                                      : (seen && !r.ck_prev)) // [R12]
                   : (seen != r.ck_prev);                     // [R06]

   always_comb begin
      n = r;
      if (!(i_make_clock && i_run_clock)) begin
         n.div = 8'h00;
         n.gen = 1'b0;
      end else if (r.div >= 8'(HALF) - 8'h01) begin
         n.div = 8'h00;
         n.gen = !r.gen;
      end else begin
         n.div = r.div + 8'h01;
      end
      n.own_dly = {r.own_dly[0], r.gen};
      n.ck_sync = {r.ck_sync[0], i_use_shared_pin ? lnk.shared_port_clock : lnk.transmit_clock};
      n.ck_prev = seen;
      if (i_smp_valid && !r.pair_v) begin
         n.pair_v = 1'b1;
         n.pi = i_i_sample;
         n.pq = i_q_sample;
      end
      if (launch) begin
         case (r.st)
            TXP_PAIR_HALF: begin
               n.txd = i_in_phase_first ? r.pq : r.pi; // [R15]
               n.mark = !i_marker_pol; // [R13]
               n.st = TXP_PAIR_EMPTY;
               n.pair_v = 1'b0;
            end
            default: begin
               // idle leaves the closing level so no pair is formed
               if (r.pair_v) begin
                  n.txd = i_in_phase_first ? r.pi : r.pq; // [R14]
                  n.mark = i_marker_pol; // [R13]
                  n.st = TXP_PAIR_HALF;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/txp_dev.sv ----
// converter end of the transmit port: registers, clocking, capture, pairing
// Function
// (R01) rrc bypass bit skips root-raised-cosine stage
// (R02) chain order: rrc, first then second halfband
// (R03) active rrc forces both halfbands active
// (R04) clock enable bit runs transmit data clocks
// (R05) half duplex direction bit: 0 tx, 1 rx
// (R06) rate bit: 0 both edges, 1 one edge
// (R07) invert bit inverts driven transmit clock
// (R08) clock mode 00 disabled, 01 input
// (R09) mode 10 internal clock, 11 dll out
// (R10) half duplex single clock uses shared pin
// (R11) two clock or full duplex: dedicated pin
// (R12) edge bit: 0 falling, 1 rising capture
// (R13) marker polarity marks each sample pair
// (R14) ordering bit decides pair's i/q order
// (R15) ordering 0 q first, 1 i first
// (R16) format bit: 0 offset binary, 1 twos
// (R17) fields read back, act after write
`default_nettype none
module txp_dev
   import txp_pkg::*;
#(
   parameter int W = TXP_SAMPLE_W,
   parameter int DEPTH = TXP_FIFO_DEPTH,
   parameter int HALF_INT = TXP_HALF_CYC,
   parameter int HALF_DLL = TXP_DLL_HALF_CYC
) (
   input wire logic i_sys_clk,          // system clock, 40 MHz
   input wire logic i_srst,             // sync reset, high
   input wire logic i_reg_wr,           // register write strobe
   input wire logic [7:0] i_reg_addr,   // register address
   input wire logic [7:0] i_reg_wdata,  // register write data
   output logic [7:0] o_reg_rdata,      // registered read data
   input wire logic i_half_duplex,      // port in half duplex mode
   input wire logic i_single_clk_pin,   // half duplex one-clock mode
   output logic o_rrc_active,           // rrc stage in use
   output logic o_hb0_active,           // first halfband in use
   output logic o_hb1_active,           // second halfband in use
   output logic [1:0] o_interp_log2,    // total interpolation, log2
   output logic o_port_is_rx,           // shared port turned to receive
   output logic o_tx_active,            // transmit capture possible
   output logic o_pair_valid,           // pair available
   input wire logic i_pair_ready,       // pair consumer ready
   output logic [W-1:0] o_i_sample,     // in-phase sample, twos comp
   output logic [W-1:0] o_q_sample,     // quadrature sample, twos comp
   output logic o_overrun,              // pulse: pair lost, fifo full
   txp_if.dev lnk                       // link pins
);
   typedef struct packed {
      logic [7:0] filt;
      logic [7:0] ifc;
      logic [7:0] rdata;
      logic [7:0] div;
      logic gen;
      logic pin;
      logic [1:0] pin_dly;
      logic [1:0] ck_sync;
      logic ck_prev;
      logic [W-1:0] d_s1;
      logic [W-1:0] d_s2;
      logic [1:0] m_sync;
      txp_pair_t st;
      logic [W-1:0] first;
      logic overrun;
   } txp_dev_st_t;

   txp_dev_st_t r;
   txp_dev_st_t n;
   txp_ck_mode_t md;
   logic clk_en;
   logic tx_act;
   logic one_pin;
   logic drive;
   logic [7:0] half;
   logic ck_seen;
   logic rise;
   logic fall;
   logic cap;
   logic push;
   logic [2*W-1:0] push_data;
   logic fifo_rdy;
   logic [2*W-1:0] pop_data;

   // offset binary becomes twos complement by flipping the sign bit
   function automatic logic [W-1:0] to_twos(input logic [W-1:0] x,
                                            input logic fmt);
      to_twos = fmt ? x : {~x[W-1], x[W-2:0]}; // [R16]
   endfunction

   assign md = txp_ck_mode_t'(r.ifc[TXP_MODE_HI:TXP_MODE_LO]);
   assign clk_en = r.filt[TXP_CLK_EN_BIT];
   assign tx_act = !i_half_duplex || !r.filt[TXP_DIR_BIT]; // [R05]
   assign one_pin = i_half_duplex && i_single_clk_pin;
   assign drive = clk_en && tx_act && md[1]; // [R04] [R09]
   assign half = (md == TXP_CK_DLL) ? 8'(HALF_DLL) : 8'(HALF_INT); // [R09]

   // rrc feeds hb0 which feeds hb1; rrc in use pins both halfbands on
   assign o_rrc_active = !r.filt[TXP_RRC_BP_BIT]; // [R01]
   assign o_hb0_active = !r.filt[TXP_HB0_BP_BIT] || o_rrc_active; // [R03]
   assign o_hb1_active = !r.filt[TXP_HB1_BP_BIT] || o_rrc_active; // [R03]
   assign o_interp_log2 = (o_rrc_active && o_hb0_active && o_hb1_active)
                          ? 2'h3
                          : 2'({1'b0, o_hb0_active} + {1'b0, o_hb1_active});
   // [R02]
   assign o_port_is_rx = i_half_duplex && r.filt[TXP_DIR_BIT]; // [R05]
   assign o_tx_active = tx_act;
   assign o_reg_rdata = r.rdata;
   assign o_overrun = r.overrun;

   // pin drivers: mode 00 leaves both off, mode 01 only listens
   assign lnk.transmit_clock_dev_o = r.pin;
   assign lnk.transmit_clock_dev_oe = md[1] && !one_pin; // [R08] [R11]
   assign lnk.shared_port_clock_dev_o = r.pin;
   assign lnk.shared_port_clock_dev_oe = md[1] && one_pin && tx_act; // [R10]

   // received clock is synchronised; own clock is delayed to match data
   assign ck_seen = (md == TXP_CK_IN) ? r.ck_sync[1] : r.pin_dly[1];
   assign rise = ck_seen && !r.ck_prev;
   assign fall = !ck_seen && r.ck_prev;
   assign cap = clk_en && tx_act && (md != TXP_CK_OFF) && // [R04] [R08]
                (r.ifc[TXP_SDR_BIT]
                 ? (r.ifc[TXP_EDGE_BIT] ? rise : fall)  // [R12]
                 : (rise || fall));                     // [R06]

   always_comb begin
      n = r;
      push = 1'b0;
      push_data = '0;
      n.overrun = 1'b0;
      // settings act from the cycle after the write
      if (i_reg_wr && i_reg_addr == TXP_FILT_ADDR) begin
         n.filt = i_reg_wdata; // [R17]
      end
      if (i_reg_wr && i_reg_addr == TXP_IFC_ADDR) begin
         n.ifc = i_reg_wdata; // [R17]
      end
      case (i_reg_addr)
         TXP_FILT_ADDR: n.rdata = r.filt; // [R17]
         TXP_IFC_ADDR: n.rdata = r.ifc;
         default: n.rdata = 8'h00;
      endcase
      // clock divider; stops low while not driving
      if (!drive) begin
         n.div = 8'h00;
         n.gen = 1'b0;
      end else if (r.div >= half - 8'h01) begin
         n.div = 8'h00;
         n.gen = !r.gen;
      end else begin
         n.div = r.div + 8'h01;
      end
      n.pin = n.gen ^ r.ifc[TXP_OINV_BIT]; // [R07]
      // an invert change moves the pin: restart so no short half follows
      if (n.pin != r.pin && n.gen == r.gen) begin
         n.div = 8'h00;
      end
      n.pin_dly = {r.pin_dly[0], r.pin};
      n.ck_sync = {r.ck_sync[0], one_pin ? lnk.shared_port_clock : lnk.transmit_clock};
      n.ck_prev = ck_seen;
      n.d_s1 = lnk.txd;
      n.d_s2 = r.d_s1;
      n.m_sync = {r.m_sync[0], lnk.tx_pair_marker};
      if (cap) begin
         // marker at polarity level opens a pair, opposite level closes it
         if (r.m_sync[1] == r.ifc[TXP_POL_BIT]) begin // [R13]
            n.first = r.d_s2;
            n.st = TXP_PAIR_HALF;
         end else begin
            case (r.st)
               TXP_PAIR_HALF: begin
                  n.st = TXP_PAIR_EMPTY;
                  push = 1'b1;
                  if (r.ifc[TXP_IFIRST_BIT]) begin // [R14] [R15]
                     push_data = {to_twos(r.first, r.ifc[TXP_FMT_BIT]),
                                  to_twos(r.d_s2, r.ifc[TXP_FMT_BIT])};
                  end else begin
                     push_data = {to_twos(r.d_s2, r.ifc[TXP_FMT_BIT]),
                                  to_twos(r.first, r.ifc[TXP_FMT_BIT])};
                  end
                  // the link cannot be held off, so a full fifo loses the pair
                  n.overrun = !fifo_rdy;
               end
               default: n.st = TXP_PAIR_EMPTY;
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         r <= '0;
         r.filt <= TXP_FILT_RST;
         r.ifc <= TXP_IFC_RST;
      end else begin
         r <= n;
      end
   end

   txp_fifo #(.W(2 * W), .DEPTH(DEPTH)) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_in_valid(push),
      .o_in_ready(fifo_rdy),
      .i_in_data(push_data),
      .o_out_valid(o_pair_valid),
      .i_out_ready(i_pair_ready),
      .o_out_data(pop_data)
   );
   assign o_i_sample = pop_data[2*W-1:W];
   assign o_q_sample = pop_data[W-1:0];
endmodule
`default_nettype wire

// ---- hdl/txp_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module txp_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 4
) (
   input wire logic i_sys_clk,        // system clock
   input wire logic i_srst,           // sync reset, high
   input wire logic i_in_valid,       // write request
   output logic o_in_ready,           // room for a word
   input wire logic [W-1:0] i_in_data, // word to store
   output logic o_out_valid,          // word available
   input wire logic i_out_ready,      // consumer takes word
   output logic [W-1:0] o_out_data    // oldest word
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } txp_fifo_st_t;
   txp_fifo_st_t r;
   txp_fifo_st_t n;
   logic full;
   logic empty;

   assign empty = (r.wp == r.rp);
   assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = r.mem[r.rp[AW-1:0]];

   always_comb begin
      n = r;
      if (i_in_valid && !full) begin
         n.mem[r.wp[AW-1:0]] = i_in_data;
         n.wp = r.wp + 1'b1;
      end
      if (i_out_ready && !empty) begin
         n.rp = r.rp + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/txp_if.sv ----
// pins between the converter's transmit port and the baseband processor
`default_nettype none
interface txp_if #(parameter int W = 12);
   logic transmit_clock_dev_o;
   logic transmit_clock_dev_oe;
   logic transmit_clock_bb_o;
   logic transmit_clock_bb_oe;
   logic shared_port_clock_dev_o;
   logic shared_port_clock_dev_oe;
   logic shared_port_clock_bb_o;
   logic shared_port_clock_bb_oe;
   logic transmit_clock;
   logic shared_port_clock;
   logic [W-1:0] txd;
   logic tx_pair_marker;
   // an undriven pin reads low
   assign transmit_clock = transmit_clock_dev_oe ? transmit_clock_dev_o : (transmit_clock_bb_oe & transmit_clock_bb_o);
   assign shared_port_clock = shared_port_clock_dev_oe ? shared_port_clock_dev_o
                                 : (shared_port_clock_bb_oe & shared_port_clock_bb_o);
   modport dev (
      output transmit_clock_dev_o, transmit_clock_dev_oe, shared_port_clock_dev_o, shared_port_clock_dev_oe,
      input transmit_clock, shared_port_clock, txd, tx_pair_marker
   );
   modport bb (
      output transmit_clock_bb_o, transmit_clock_bb_oe, shared_port_clock_bb_o, shared_port_clock_bb_oe,
      output txd, tx_pair_marker,
      input transmit_clock, shared_port_clock
   );
endinterface
`default_nettype wire

// ---- hdl/txp_pkg.sv ----
// shared constants and types for the transmit data port configuration
`default_nettype none
package txp_pkg;
   localparam int TXP_SAMPLE_W = 12;
   localparam int TXP_FIFO_DEPTH = 4;
   localparam int TXP_SYS_CLK_NS = 25;
   localparam int TXP_LINK_CLK_NS = 200;
   // half period of a derived link clock, in system cycles
   localparam int TXP_HALF_CYC = TXP_LINK_CLK_NS / (2 * TXP_SYS_CLK_NS);
   localparam int TXP_DLL_HALF_CYC = 5;
   // register offsets and reset values
   localparam logic [7:0] TXP_FILT_ADDR = 8'h30;
   localparam logic [7:0] TXP_IFC_ADDR = 8'h31;
   localparam logic [7:0] TXP_FILT_RST = 8'h00;
   localparam logic [7:0] TXP_IFC_RST = 8'h00;
   // filter_bypass_and_port_control fields
   localparam int TXP_HB1_BP_BIT = 4;
   localparam int TXP_HB0_BP_BIT = 3;
   localparam int TXP_RRC_BP_BIT = 2;
   localparam int TXP_CLK_EN_BIT = 1;
   localparam int TXP_DIR_BIT = 0;
   // tx_port_interface_control fields
   localparam int TXP_SDR_BIT = 7;
   localparam int TXP_OINV_BIT = 6;
   localparam int TXP_MODE_HI = 5;
   localparam int TXP_MODE_LO = 4;
   localparam int TXP_EDGE_BIT = 3;
   localparam int TXP_POL_BIT = 2;
   localparam int TXP_IFIRST_BIT = 1;
   localparam int TXP_FMT_BIT = 0;
   typedef enum logic [1:0] {
      TXP_CK_OFF = 2'b00,
      TXP_CK_IN  = 2'b01,
      TXP_CK_INT = 2'b10,
      TXP_CK_DLL = 2'b11
   } txp_ck_mode_t;
   typedef enum logic {
      TXP_PAIR_EMPTY = 1'b0,
      TXP_PAIR_HALF  = 1'b1
   } txp_pair_t;
endpackage
`default_nettype wire

// ---- tb/tx_data_port_config_bench.sv ----
// self-checking bench for both ends of the transmit data port
`default_nettype none
module tx_data_port_config_bench
   import txp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] f; logic hd; logic [6:0] ex;} txp_frow_t;
   typedef struct packed {logic [7:0] ifc; logic hd; logic sc;} txp_lrow_t;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, hd = 1'b0, sc = 1'b0, pr = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd;
   logic rrc, hb0, hb1, is_rx, tx_act, pv, ovr, sr, fmt;
   logic [1:0] il2;
   logic [11:0] oi, oq, w_open, w_close, si = 12'h000, sq = 12'h000;
   logic sv = 1'b0, mk = 1'b0, run = 1'b0, shp = 1'b0;
   logic se = 1'b0, srise = 1'b0, pol = 1'b0, ifst = 1'b0;
   int mismatches = 0, comparisons = 0, ovr_cnt = 0, o0, j, k;
   // expected outputs: {rrc, hb0, hb1, log2, rx, tx active}
   txp_frow_t frows [8] = '{
      '{8'h00, 1'b0, 7'h7D},
      '{8'h04, 1'b0, 7'h39},
      '{8'h0C, 1'b0, 7'h15},
      '{8'h14, 1'b0, 7'h25},
      '{8'h1C, 1'b1, 7'h01},
      '{8'h1D, 1'b1, 7'h02},
      '{8'h19, 1'b0, 7'h7D},
      '{8'h11, 1'b1, 7'h7E}};
   txp_lrow_t lrows [6] = '{
      '{8'h20, 1'b0, 1'b0},
      '{8'hBF, 1'b0, 1'b0},
      '{8'hE6, 1'b0, 1'b0},
      '{8'h1B, 1'b0, 1'b0},
      '{8'h2D, 1'b1, 1'b1},
      '{8'h24, 1'b0, 1'b0}};
   always #12.5 clk = ~clk;
   txp_if #(.W(TXP_SAMPLE_W)) u_txp_if ();
   txp_dev u_txp_dev (.i_sys_clk(clk), .i_srst(srst), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_half_duplex(hd), .i_single_clk_pin(sc), .o_rrc_active(rrc),
      .o_hb0_active(hb0), .o_hb1_active(hb1), .o_interp_log2(il2),
      .o_port_is_rx(is_rx), .o_tx_active(tx_act), .o_pair_valid(pv),
      .i_pair_ready(pr), .o_i_sample(oi), .o_q_sample(oq),
      .o_overrun(ovr), .lnk(u_txp_if.dev));
   txp_bb u_txp_bb (.i_sys_clk(clk), .i_srst(srst), .i_smp_valid(sv),
      .o_smp_ready(sr), .i_i_sample(si), .i_q_sample(sq),
      .i_make_clock(mk), .i_run_clock(run), .i_use_shared_pin(shp),
      .i_single_edge(se), .i_sample_rising(srise), .i_marker_pol(pol),
      .i_in_phase_first(ifst), .lnk(u_txp_if.bb));
   txp_chk #(.W(TXP_SAMPLE_W)) u_chk (.i_sys_clk(clk), .i_srst(srst),
      .transmit_clock_dev_o(u_txp_if.transmit_clock_dev_o),
      .transmit_clock_dev_oe(u_txp_if.transmit_clock_dev_oe),
      .transmit_clock_bb_oe(u_txp_if.transmit_clock_bb_oe),
      .shared_port_clock_dev_o(u_txp_if.shared_port_clock_dev_o),
      .shared_port_clock_dev_oe(u_txp_if.shared_port_clock_dev_oe),
      .shared_port_clock_bb_oe(u_txp_if.shared_port_clock_bb_oe),
      .txd(u_txp_if.txd), .tx_pair_marker(u_txp_if.tx_pair_marker));
   // last words seen on the wire, split by marker level
   always @(negedge clk) begin
      if (ovr === 1'b1)
         ovr_cnt++;
      if (u_txp_if.tx_pair_marker === pol)
         w_open <= u_txp_if.txd;
      else
         w_close <= u_txp_if.txd;
   end
   task automatic test_done();
      if (mismatches == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      rd = rdata;
   endtask
   function automatic logic [11:0] flip(input logic [11:0] v, input logic f);
      return f ? v : {~v[11], v[10:0]};
   endfunction
   task automatic send(input int n);
      int t;
      @(negedge clk);
      sv = 1'b1;
      si = 12'h8A5 + 12'(n);
      sq = 12'h35C - 12'(n);
      // ready seen at a falling edge: the next rising edge takes the pair
      for (t = 0; t < 400 && sr !== 1'b1; t++)
         @(negedge clk);
      check(sr, 1'b1);
      @(negedge clk);
      sv = 1'b0;
   endtask
   task automatic get(input int n);
      int t;
      @(negedge clk);
      for (t = 0; t < 400 && pv !== 1'b1; t++)
         @(negedge clk);
      check(pv, 1'b1);
      check(oi, flip(12'h8A5 + 12'(n), fmt));
      check(oq, flip(12'h35C - 12'(n), fmt));
      pr = 1'b1;
      @(negedge clk);
      pr = 1'b0;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      srst = 1'b0;
      rd_reg(TXP_IFC_ADDR);
      check(rd, TXP_IFC_RST);
      foreach (frows[k]) begin
         hd = frows[k].hd;
         wr_reg(TXP_FILT_ADDR, frows[k].f);
         rd_reg(TXP_FILT_ADDR);
         check(rd, frows[k].f);
         check({rrc, hb0, hb1, il2, is_rx, tx_act}, frows[k].ex);
      end
      foreach (lrows[k]) begin
         wr_reg(TXP_IFC_ADDR, 8'h00);
         run = 1'b0;
         repeat (20) @(negedge clk);
         hd = lrows[k].hd;
         sc = lrows[k].sc;
         shp = lrows[k].hd & lrows[k].sc;
         mk = lrows[k].ifc[5:4] == 2'b01;
         {se, srise, pol, ifst, fmt} = {lrows[k].ifc[7], lrows[k].ifc[3:0]};
         wr_reg(TXP_FILT_ADDR, 8'h02);
         wr_reg(TXP_IFC_ADDR, lrows[k].ifc);
         run = 1'b1;
         rd_reg(TXP_IFC_ADDR);
         check(rd, lrows[k].ifc);
         for (j = 0; j < 2; j++)
            send(j);
         for (j = 0; j < 2; j++)
            get(j);
         check(w_open, ifst ? si : sq);
         check(w_close, ifst ? sq : si);
      end
      // consumer stalls: four pairs fill the fifo, the fifth is lost
      o0 = ovr_cnt;
      for (j = 0; j < 5; j++)
         send(j);
      repeat (60) @(negedge clk);
      check(16'(ovr_cnt - o0), 16'h0001);
      for (j = 0; j < 4; j++)
         get(j);
      check(pv, 1'b0);
      // baseband makes the clock, so only enable or direction stops capture
      wr_reg(TXP_IFC_ADDR, 8'h10);
      mk = 1'b1;
      {se, srise, pol, ifst, fmt} = 5'h00;
      wr_reg(TXP_FILT_ADDR, 8'h00);
      send(7);
      repeat (80) @(negedge clk);
      check(pv, 1'b0);
      hd = 1'b1;
      wr_reg(TXP_FILT_ADDR, 8'h03);
      send(8);
      repeat (80) @(negedge clk);
      check(pv, 1'b0);
      wr_reg(8'h45, 8'hFF);
      rd_reg(8'h45);
      check(rd, 8'h00);
      // a reset in mid-run must bring back the defaults
      wr_reg(TXP_IFC_ADDR, 8'h5F);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      rd_reg(TXP_IFC_ADDR);
      check(rd, TXP_IFC_RST);
      check({rrc, hb0, hb1, il2, is_rx, tx_act}, 7'h7D);
      test_done();
   end
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule
`default_nettype wire

// ---- tb/txp_chk.sv ----
// concurrent checks on the link pins between the two port ends
`default_nettype none
module txp_chk #(
   parameter int W = 12
) (
   input wire logic i_sys_clk,       // system clock
   input wire logic i_srst,          // sync reset, high
   input wire logic transmit_clock_dev_o,     // device drive of transmit_clock
   input wire logic transmit_clock_dev_oe,    // device drives transmit_clock
   input wire logic transmit_clock_bb_oe,     // baseband drives transmit_clock
   input wire logic shared_port_clock_dev_o,    // device drive of shared_port_clock
   input wire logic shared_port_clock_dev_oe,   // device drives shared_port_clock
   input wire logic shared_port_clock_bb_oe,    // baseband drives shared_port_clock
   input wire logic [W-1:0] txd,     // sample bus
   input wire logic tx_pair_marker   // pair marker
);
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic tp;
      logic ta;
      logic [3:0] tc;
      logic rp;
      logic ra;
      logic [3:0] rc;
   } txp_chk_st_t;
   txp_chk_st_t st_r;
   txp_chk_st_t st_nxt;
   logic t_chg;
   logic r_chg;
   logic no_clk;
   assign t_chg = transmit_clock_dev_oe && (transmit_clock_dev_o != st_r.tp);
   assign r_chg = shared_port_clock_dev_oe && (shared_port_clock_dev_o != st_r.rp);
   assign no_clk = !(transmit_clock_dev_oe | transmit_clock_bb_oe |
                     shared_port_clock_dev_oe | shared_port_clock_bb_oe);
   // half period judged only between two toggles of one drive span
   always_comb begin
      st_nxt = st_r;
      st_nxt.tp = transmit_clock_dev_o;
      st_nxt.rp = shared_port_clock_dev_o;
      st_nxt.tc = t_chg ? 4'h1 : st_r.tc + {3'h0, st_r.tc != 4'hF};
      st_nxt.rc = r_chg ? 4'h1 : st_r.rc + {3'h0, st_r.rc != 4'hF};
      st_nxt.ta = transmit_clock_dev_oe && (st_r.ta || t_chg);
      st_nxt.ra = shared_port_clock_dev_oe && (st_r.ra || r_chg);
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   AST_TX_HALF: assert property (t_chg && st_r.ta |-> st_r.tc >= 4'h4)
      else $error("transmit clock half period too short");
   AST_TRX_HALF: assert property (r_chg && st_r.ra |->
      st_r.rc >= 4'h4)
      else $error("shared clock half period too short");
   AST_TX_ONE: assert property (!(transmit_clock_dev_oe && transmit_clock_bb_oe))
      else $error("two drivers on transmit_clock");
   AST_TRX_ONE: assert property (!(shared_port_clock_dev_oe && shared_port_clock_bb_oe))
      else $error("two drivers on shared_port_clock");
   AST_DEV_ONE_PIN: assert property (!(transmit_clock_dev_oe && shared_port_clock_dev_oe))
      else $error("device drives both clock pins");
   AST_BB_ONE_PIN: assert property (!(transmit_clock_bb_oe && shared_port_clock_bb_oe))
      else $error("baseband drives both clock pins");
   AST_RST_OE: assert property ($fell(i_srst) |->
      !transmit_clock_dev_oe && !shared_port_clock_dev_oe)
      else $error("clock pin driven after reset");
   AST_IDLE_HOLD: assert property (no_clk [*8] |->
      $stable(txd) && $stable(tx_pair_marker))
      else $error("data moved with no link clock");
endmodule
`default_nettype wire
